// ==== pwm_pkg.sv ====
// package: register map, field layout and state for the four-channel modulator
package pwm_pkg;
  // printed register offsets (bytes, all multiples of four -> indices)
  localparam logic [7:0] idx_modulator_control = 8'hf1;
  localparam logic [7:0] idx_prescale_ch3 = 8'hf2;
  localparam logic [7:0] idx_duty_ch2 = 8'hf4;
  localparam logic [7:0] idx_duty_ch3 = 8'hf5;
  localparam logic [7:0] idx_prescale_ch2 = 8'hf6;
  localparam logic [7:0] idx_prescale_ch1 = 8'hfb;
  localparam logic [7:0] idx_duty_ch0 = 8'hfc;
  localparam logic [7:0] idx_duty_ch1 = 8'hfd;
  localparam logic [7:0] idx_prescale_ch0 = 8'hfe;
  // control register fields
  localparam int bit_out0_enable = 0;
  localparam int bit_out1_enable = 1;
  localparam int bit_module_a_single_select = 2;
  localparam int bit_out2_enable = 4;
  localparam int bit_out3_enable = 5;
  localparam int bit_module_b_single_select = 6;
  localparam int bit_global_disable = 7;
  localparam logic [7:0] control_used_mask = 8'hf7;
  // reset values
  localparam logic [7:0] control_reset = 8'h80;
  localparam logic [7:0] prescale_reset = 8'h00;
  localparam logic [7:0] duty_reset = 8'h00;
  // counter wraps after this value (modulo 255)
  localparam logic [7:0] count_last = 8'hfe;
  localparam logic [7:0] zero8 = 8'h00;
  // apb: one-cycle answer, no wait states
  typedef enum logic [1:0] {
    apb_idle_type_st = 2'b01,
    apb_done_type_st = 2'b10
  } apb_state_type;
  typedef struct packed {
    logic [7:0] control;
    logic [3:0][7:0] prescale;
    logic [3:0][7:0] duty;
  } regs_type;
endpackage

// ==== quad_pwm_generator.sv ====
// four-channel pulse width modulator with an apb register slave
`timescale 1ns/1ns
module quad_pwm_generator (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // push-pull modulator pins, port 4 bits 0 to 3
  output logic [3:0] port4_pin
);

  pwm_pkg::regs_type regs_reg, regs_next;
  pwm_pkg::apb_state_type apb_reg, apb_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;
  logic half_reg, half_next;
  logic [3:0][7:0] pre_reg, pre_next;
  logic [3:0][7:0] cnt_reg, cnt_next;
  logic [3:0] pin_reg, pin_next;

  logic [9:0] word_index;
  logic addr_ok;
  logic hit;
  logic [7:0] sel_value;

  // register index is byte address over four
  assign word_index = paddr[11:2];

  // address decode and readback
  always_comb begin
    addr_ok = (paddr[1:0] == 2'b00) && (word_index[9:8] == 2'b00);
    hit = 1'b1;
    sel_value = 8'h00;
    unique case (word_index[7:0])
      pwm_pkg::idx_modulator_control: sel_value = regs_reg.control & pwm_pkg::control_used_mask;
      pwm_pkg::idx_prescale_ch0: sel_value = regs_reg.prescale[0];
      pwm_pkg::idx_prescale_ch1: sel_value = regs_reg.prescale[1];
      pwm_pkg::idx_prescale_ch2: sel_value = regs_reg.prescale[2];
      pwm_pkg::idx_prescale_ch3: sel_value = regs_reg.prescale[3];
      pwm_pkg::idx_duty_ch0: sel_value = regs_reg.duty[0];
      pwm_pkg::idx_duty_ch1: sel_value = regs_reg.duty[1];
      pwm_pkg::idx_duty_ch2: sel_value = regs_reg.duty[2];
      pwm_pkg::idx_duty_ch3: sel_value = regs_reg.duty[3];
      default: hit = 1'b0;
    endcase
    hit = hit && addr_ok;
  end

  // apb slave: setup cycle, then one access cycle answered at once
  always_comb begin
    apb_next = apb_reg;
    regs_next = regs_reg;
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    unique case (apb_reg)
      pwm_pkg::apb_idle_type_st: begin
        if (psel && !penable) begin
          apb_next = pwm_pkg::apb_done_type_st;
          pslverr_next = !hit;
          prdata_next = (!pwrite && hit) ? {24'h00_0000, sel_value} : 32'h0000_0000;
        end
      end
      pwm_pkg::apb_done_type_st: begin
        apb_next = pwm_pkg::apb_idle_type_st;
        pslverr_next = 1'b0;
        prdata_next = 32'h0000_0000;
        if (psel && penable && pwrite && hit) begin
          // written values reach the comparators on the next cycle
          unique case (word_index[7:0])
            pwm_pkg::idx_modulator_control: regs_next.control = pwdata[7:0] & pwm_pkg::control_used_mask;
            pwm_pkg::idx_prescale_ch0: regs_next.prescale[0] = pwdata[7:0];
            pwm_pkg::idx_prescale_ch1: regs_next.prescale[1] = pwdata[7:0];
            pwm_pkg::idx_prescale_ch2: regs_next.prescale[2] = pwdata[7:0];
            pwm_pkg::idx_prescale_ch3: regs_next.prescale[3] = pwdata[7:0];
            pwm_pkg::idx_duty_ch0: regs_next.duty[0] = pwdata[7:0];
            pwm_pkg::idx_duty_ch1: regs_next.duty[1] = pwdata[7:0];
            pwm_pkg::idx_duty_ch2: regs_next.duty[2] = pwdata[7:0];
            pwm_pkg::idx_duty_ch3: regs_next.duty[3] = pwdata[7:0];
            default: regs_next = regs_reg;
          endcase
        end
      end
      default: apb_next = pwm_pkg::apb_idle_type_st;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      apb_reg <= pwm_pkg::apb_idle_type_st;
      regs_reg.control <= pwm_pkg::control_reset;
      regs_reg.prescale <= {4{pwm_pkg::prescale_reset}};
      regs_reg.duty <= {4{pwm_pkg::duty_reset}};
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      apb_reg <= apb_next;
      regs_reg <= regs_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  // one-hot state: the done bit is the ready flop itself
  assign pready = apb_reg[1];

  // modulation: four prescaler/counter slots; in dual mode slots 1 and 3 are
  // idle and channels 1 and 3 compare against slots 0 and 2
  logic disabled;
  logic [3:0] slot_runs;
  logic [3:0][7:0] cmp_count;

  always_comb begin
    disabled = regs_reg.control[pwm_pkg::bit_global_disable];
    slot_runs[0] = 1'b1;
    slot_runs[2] = 1'b1;
    slot_runs[1] = regs_reg.control[pwm_pkg::bit_module_a_single_select];
    slot_runs[3] = regs_reg.control[pwm_pkg::bit_module_b_single_select];
    // divide-by-two stage models the oscillator-over-two input clock
    half_next = disabled ? 1'b0 : !half_reg;
    pre_next = pre_reg;
    cnt_next = cnt_reg;
    for (int i = 0; i < 4; i++) begin
      if (disabled || !slot_runs[i]) begin
        pre_next[i] = pwm_pkg::zero8;
        cnt_next[i] = pwm_pkg::zero8;
      end else if (half_reg) begin
        if (pre_reg[i] >= regs_reg.prescale[i]) begin
          pre_next[i] = pwm_pkg::zero8;
          cnt_next[i] = (cnt_reg[i] == pwm_pkg::count_last) ? pwm_pkg::zero8 : cnt_reg[i] + 8'h01;
        end else begin
          pre_next[i] = pre_reg[i] + 8'h01;
        end
      end
    end
    // shared counters in dual mode
    cmp_count[0] = cnt_reg[0];
    cmp_count[2] = cnt_reg[2];
    cmp_count[1] = slot_runs[1] ? cnt_reg[1] : cnt_reg[0];
    cmp_count[3] = slot_runs[3] ? cnt_reg[3] : cnt_reg[2];
    for (int i = 0; i < 4; i++) begin
      // greater gives low, equal or less gives high; FFH never below counter
      pin_next[i] = !(regs_reg.duty[i] > cmp_count[i]);
    end
    // disabled or channel off: pin rests low
    if (disabled) begin
      pin_next = 4'h0;
    end
    if (!regs_reg.control[pwm_pkg::bit_out0_enable]) pin_next[0] = 1'b0;
    if (!regs_reg.control[pwm_pkg::bit_out1_enable]) pin_next[1] = 1'b0;
    if (!regs_reg.control[pwm_pkg::bit_out2_enable]) pin_next[2] = 1'b0;
    if (!regs_reg.control[pwm_pkg::bit_out3_enable]) pin_next[3] = 1'b0;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      half_reg <= 1'b0;
      pre_reg <= {4{pwm_pkg::zero8}};
      cnt_reg <= {4{pwm_pkg::zero8}};
      pin_reg <= 4'h0;
    end else begin
      half_reg <= half_next;
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      pin_reg <= pin_next;
    end
  end

  // always driven, no enable: pins serve only the modulator
  assign port4_pin = pin_reg;

endmodule

// ==== pwm_props.sv ====
// checker: port-level properties of the modulator
`timescale 1ns/1ns
module pwm_props (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic [3:0] port4_pin
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic [7:0] ctl_reg;
  logic [7:0] ctl_next;
  logic wr;
  // shadow of the control register, so pin rules can see the mode
  assign wr = psel && penable && pready && pwrite && !pslverr;
  always_comb begin
    ctl_next = ctl_reg;
    if (wr && paddr == 12'h3c4) begin
      ctl_next = pwdata[7:0];
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctl_reg <= pwm_pkg::control_reset;
    end else begin
      ctl_reg <= ctl_next;
    end
  end
  ready_one_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  bad_addr_a: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0000_0000)
    else $error("misaligned access not refused");
  resv_bit_a: assert property (psel && !penable && !pwrite && paddr == 12'h3c4 |=> prdata[31:3] == 29'h0 || prdata[31:8] == 24'h00_0000 && !prdata[3])
    else $error("reserved control bits read nonzero");
  reset_low_a: assert property ($rose(rstn) |-> port4_pin == 4'h0)
    else $error("pins not low after reset");
  off_low_a: assert property (ctl_reg[7] [*3] |-> port4_pin == 4'h0)
    else $error("pins active while disabled");
  chan_off_a: assert property (!ctl_reg[0] [*3] |-> !port4_pin[0])
    else $error("pin 0 active while its enable is clear");
  stop_now_a: assert property (wr && paddr == 12'h3c4 && pwdata[7] |-> ##2 port4_pin == 4'h0)
    else $error("disable write did not stop pins");
  duty_zero_a: assert property (wr && paddr == 12'h3f0 && pwdata[7:0] == 8'h00 && ctl_reg[7:0] == 8'h31
    |-> ##2 port4_pin[0] [*4])
    else $error("duty 00 not constant high");
  duty_full_a: assert property (wr && paddr == 12'h3f0 && pwdata[7:0] == 8'hff && ctl_reg[7:0] == 8'h31
    |-> ##2 !port4_pin[0] [*8])
    else $error("duty ff not low at once");
  cover property (wr && paddr == 12'h3c4 && pwdata[6]);
  cover property ($rose(port4_pin[3]));
  cover property (pslverr);
endmodule
bind quad_pwm_generator pwm_props props_i (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .port4_pin);

// ==== pwm_load.sv ====
// partner: loads on the four pins, timing the last full high and low runs
`timescale 1ns/1ns
module pwm_load (
  // clock and pins
  input wire logic clock,
  input wire logic [3:0] port4_pin,
  // measured runs in clocks
  output int hi_len [4],
  output int lo_len [4]
);
  int run [4];
  logic [3:0] last = 4'h0;
  always @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      run[i] <= (port4_pin[i] !== last[i]) ? 1 : run[i] + 1;
      if (port4_pin[i] !== last[i] && last[i]) begin
        hi_len[i] <= run[i];
      end else if (port4_pin[i] !== last[i]) begin
        lo_len[i] <= run[i];
      end
    end
    last <= port4_pin;
  end
endmodule

// ==== tb_quad_pwm_generator.sv ====
// testbench: registers, waveform timing and fixed levels of the modulator
`timescale 1ns/1ns
module tb_quad_pwm_generator;
  logic clock, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] port4_pin;
  int hi_len [4], lo_len [4];
  int error_cnt = 0, cmp_count = 0;
  logic [11:0] pre_a [4] = '{12'h3f8, 12'h3ec, 12'h3d8, 12'h3c8};
  logic [11:0] duty_a [4] = '{12'h3f0, 12'h3f4, 12'h3d0, 12'h3d4};
  quad_pwm_generator DUT (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .port4_pin);
  pwm_load load (.clock, .port4_pin, .hi_len, .lo_len);
  initial begin
    clock = 0;
    forever #10 clock = ~clock;
  end
  task automatic test_done;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n = 0;
    @(posedge clock);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20) begin
      error_cnt++;
      test_done();
    end
  endtask
  task automatic t_regs;
    apb(0, 12'h3c4, 0);
    chk("control", 32'h0000_0080, rd);
    apb(1, 12'h3c4, 32'h0000_00ff);
    apb(0, 12'h3c4, 0);
    chk("control", 32'h0000_00f7, rd);
    for (int i = 0; i < 4; i++) begin
      apb(1, pre_a[i], 32'h0000_00a5);
      apb(0, pre_a[i], 0);
      chk("prescale", 32'h0000_00a5, rd);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1, duty_a[i], 32'h0000_015a);
      apb(0, duty_a[i], 0);
      chk("duty", 32'h0000_005a, rd);
    end
    apb(0, 12'h000, 0);
    chk("unmapped data", 32'h0000_0000, rd);
    chk("unmapped error", 32'h0000_0001, {31'h0, err});
  endtask
  task automatic t_wave;
    int f;
    for (int i = 0; i < 4; i++) begin
      apb(1, pre_a[i], i + 1);
      apb(1, duty_a[i], 32 * (i + 1));
    end
    for (int m = 0; m < 2; m++) begin
      apb(1, 12'h3c4, m ? 32'h0000_0077 : 32'h0000_0033);
      repeat (6000) @(posedge clock);
      for (int i = 0; i < 4; i++) begin
        f = m ? 2 * (i + 2) : 2 * ((i & 2) + 2);
        chk("low time", f * 32 * (i + 1), lo_len[i]);
        chk("high time", f * (255 - 32 * (i + 1)), hi_len[i]);
      end
    end
  endtask
  task automatic t_edge;
    apb(1, 12'h3c4, 32'h0000_0031);
    apb(1, duty_a[0], 0);
    repeat (600) @(posedge clock);
    chk("pin0 high", 1, port4_pin[0]);
    chk("pin1 off", 0, port4_pin[1]);
    apb(1, duty_a[0], 32'h0000_00ff);
    repeat (600) @(posedge clock);
    chk("pin0 low", 0, port4_pin[0]);
    apb(1, 12'h3c4, 32'h0000_00b3);
    repeat (4) @(posedge clock);
    chk("pins off", 0, port4_pin);
  endtask
  initial begin
    rstn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    repeat (3) @(posedge clock);
    rstn <= 1;
    t_regs();
    t_wave();
    t_edge();
    test_done();
  end
endmodule
